// ---- core/ebp_pkg.sv ----
/*
  Package of the external bus cycle sequencer: register map, field
  positions, reset values and state encoding.
  Assumes a 32-bit APB host and a 50 MHz system clock.
*/
package ebp_pkg;

  // ===========================================================
  // Register offsets (byte addresses)
  // ===========================================================
  localparam logic [7:0] EBP_TIMING_OFS  = 8'h00;
  localparam logic [7:0] EBP_CTRL_OFS    = 8'h04;
  localparam logic [7:0] EBP_ADDR_OFS    = 8'h08;
  localparam logic [7:0] EBP_WDATA_OFS   = 8'h0c;
  localparam logic [7:0] EBP_CMD_OFS     = 8'h10;
  localparam logic [7:0] EBP_STATUS_OFS  = 8'h14;
  localparam logic [7:0] EBP_RDATA_OFS   = 8'h18;

  // ===========================================================
  // Timing register fields (chip_select_timing_config)
  // ===========================================================
  localparam int EBP_AB_POS   = 0;   // 1 bit: 0 -> 1 unit, 1 -> 2 units
  localparam int EBP_ABX_POS  = 1;   // 2 bits: extra units on window change
  localparam int EBP_C_POS    = 3;   // 2 bits
  localparam int EBP_D_POS    = 5;   // 1 bit
  localparam int EBP_E_POS    = 6;   // 5 bits: length minus one
  localparam int EBP_F_POS    = 11;  // 2 bits
  localparam int EBP_UNIT_POS = 16;  // 4 bits: clocks per unit minus one

  // Control register fields
  localparam int EBP_MUX_POS    = 0;
  localparam int EBP_RDYEN_POS  = 1;
  localparam int EBP_RDYPOL_POS = 2;
  localparam int EBP_RDYASY_POS = 3;

  // Command register fields
  localparam int EBP_WRITE_POS  = 0;
  localparam int EBP_CS_POS     = 4;  // 2 bits: chip select number
  localparam int EBP_UBE_POS    = 8;

  // ===========================================================
  // Reset values
  // ===========================================================
  localparam logic [31:0] EBP_TIMING_RST = 32'h0000_0000;
  localparam logic [31:0] EBP_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] EBP_ZERO       = 32'h0000_0000;

  // Window of the address that forces the setup extension
  localparam int EBP_WINDOW_LSB = 16;

  // ===========================================================
  // Sequencer state, one-hot
  // ===========================================================
  typedef enum logic [5:0] {
    EBP_IDLE = 6'h01,
    EBP_AB   = 6'h02,
    EBP_C    = 6'h04,
    EBP_D    = 6'h08,
    EBP_E    = 6'h10,
    EBP_F    = 6'h20
  } ebp_state_e;

endpackage : ebp_pkg

// ---- core/ebp_ready_sync.sv ----
/*
  Ready input conditioner: polarity select and optional two-stage
  synchroniser for an asynchronous ready.
  Assumes ready_in is synchronous to pclk when async_mode is low.
*/
`timescale 1ns/1ps
module ebp_ready_sync
  import ebp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ready_in,
  input  wire logic active_low,
  input  wire logic async_mode,
  output logic      ready_ok
);

  logic meta;
  logic sync;

  // ===========================================================
  // Two-stage catch; meta is read only by sync
  // ===========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
    end
    else
    begin
      meta <= ready_in;  // [RQ12]
      sync <= meta;
    end
  end

  // Polarity applied after the stages, costs no extra cycle
  always_comb
  begin
    ready_ok = (async_mode ? sync : ready_in) ^ active_low;  // [RQ11] [RQ12]
  end

endmodule : ebp_ready_sync

// ---- core/ebp_sequencer.sv ----
/*
  External bus cycle sequencer with APB register access. Runs one
  external cycle per command through five timed phases.
  Assumes an APB master, a 50 MHz pclk, and an external module that
  obeys the ready and read data hold conventions of this bus.
*/
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// (RQ1) Each cycle walks address setup, command delay, write setup, access, hold.
// (RQ2) Each phase length comes from the timing register in timing units.
// (RQ3) Address setup is 1 or 2 units plus 0 to 3 units on a window change.
// (RQ4) Command delay is 0 to 3 units and access is 1 to 32 units.
// (RQ5) Write setup, also the multiplexed turnaround, is 0 or 1 unit.
// (RQ6) The closing hold phase is 0 to 3 units.
// (RQ7) With ready enabled the external module ends the stretched access.
// (RQ8) Read data is captured on the edge that ends the strobe and moves on.
// (RQ9) A later address change cannot spoil captured demultiplexed read data.
// (RQ10) The module keeps read data valid until the read strobe rises.
// (RQ11) Software selects the active level of ready.
// (RQ12) Asynchronous ready passes an extra synchroniser stage.
// (RQ13) Ready inactive at the sample adds a wait, active ends the access.
// (RQ14) Multiplexed mode shares address and data lines with a latch strobe.
// (RQ15) Chip select spans the whole cycle, strobes only the access phase.
module ebp_sequencer
  import ebp_pkg::*;
#(
  parameter int AW = 24,
  parameter int DW = 16,
  parameter int NCS = 4
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic [AW-1:0]      address_lines,
  output logic [DW-1:0]      data_lines_out,
  output logic               data_lines_oen,
  input  wire logic [DW-1:0] data_lines_in,
  output logic [DW-1:0]      shared_addr_data_lines_out,
  output logic               shared_addr_data_lines_oen,
  input  wire logic [DW-1:0] shared_addr_data_lines_in,
  output logic               addr_latch,
  output logic [NCS-1:0]     chip_select_n,
  output logic               read_n,
  output logic               write_n,
  output logic               upper_byte_enable_n,
  input  wire logic          ready_in
);

  ebp_state_e  state;
  ebp_state_e  next_state;
  logic [31:0] chip_select_timing_config;
  logic [3:0]  ctrl;
  logic [AW-1:0] cmd_addr;
  logic [DW-1:0] cmd_wdata;
  logic [DW-1:0] read_data;
  logic [AW-1:0] last_addr;
  logic        cmd_write;
  logic        busy;
  logic [5:0]  phase_cnt;
  logic [3:0]  unit_cnt;
  logic        unit_tick;
  logic [5:0]  phase_len;
  logic        ready_ok;
  logic        window_change;
  logic        apb_wr;
  logic        go;

  // ===========================================================
  // APB slave: zero wait states
  // ===========================================================
  assign apb_wr = psel && penable && pwrite;
  assign go = apb_wr && (paddr == EBP_CMD_OFS) && !busy;

  // Phase length in units for a given state
  function automatic logic [5:0] len_of(input ebp_state_e s,
                                        input logic [31:0] t,
                                        input logic wc);
    logic [5:0] l;
    l = 6'h00;
    case (s)
      EBP_AB: l = 6'(t[EBP_AB_POS]) + 6'h01
                  + (wc ? 6'(t[EBP_ABX_POS +: 2]) : 6'h00);  // [RQ3]
      EBP_C:  l = 6'(t[EBP_C_POS +: 2]);                   // [RQ4]
      EBP_D:  l = 6'(t[EBP_D_POS]);                        // [RQ5]
      EBP_E:  l = 6'(t[EBP_E_POS +: 5]) + 6'h01;           // [RQ4]
      EBP_F:  l = 6'(t[EBP_F_POS +: 2]);                   // [RQ6]
      default: l = 6'h00;
    endcase
    return l;
  endfunction : len_of

  // Register writes; busy blocks timing changes mid cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chip_select_timing_config <= EBP_TIMING_RST;
      ctrl      <= EBP_CTRL_RST[3:0];
      cmd_addr  <= '0;
      cmd_wdata <= '0;
    end
    else if (apb_wr && !busy)
    begin
      case (paddr)
        EBP_TIMING_OFS: chip_select_timing_config <= pwdata;  // [RQ2]
        EBP_CTRL_OFS:   ctrl      <= pwdata[3:0];
        EBP_ADDR_OFS:   cmd_addr  <= pwdata[AW-1:0];
        EBP_WDATA_OFS:  cmd_wdata <= pwdata[DW-1:0];
        default: ;
      endcase
    end
  end

  // Read mux, registered; unmapped answers zero with error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= EBP_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= EBP_ZERO;
      if (psel && !penable)
      begin
        case (paddr)
          EBP_TIMING_OFS: prdata <= chip_select_timing_config;
          EBP_CTRL_OFS:   prdata <= 32'(ctrl);
          EBP_ADDR_OFS:   prdata <= 32'(cmd_addr);
          EBP_WDATA_OFS:  prdata <= 32'(cmd_wdata);
          EBP_CMD_OFS:    prdata <= EBP_ZERO;
          EBP_STATUS_OFS: prdata <= 32'({state, busy});
          EBP_RDATA_OFS:  prdata <= 32'(read_data);
          default:        pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ===========================================================
  // Ready conditioning
  // ===========================================================
  ebp_ready_sync u_rdy (
    .pclk       (pclk),
    .presetn    (presetn),
    .ready_in   (ready_in),
    .active_low (ctrl[EBP_RDYPOL_POS]),
    .async_mode (ctrl[EBP_RDYASY_POS]),
    .ready_ok   (ready_ok)
  );

  // ===========================================================
  // Phase sequencer
  // ===========================================================
  assign window_change = cmd_addr[AW-1:EBP_WINDOW_LSB]
                         != last_addr[AW-1:EBP_WINDOW_LSB];
  assign unit_tick = (unit_cnt == chip_select_timing_config[EBP_UNIT_POS +: 4]);
  assign phase_len = len_of(state, chip_select_timing_config, window_change);

  // Next phase; zero-length phases fall straight through
  always_comb
  begin
    next_state = state;
    case (state)
      EBP_IDLE: if (go) next_state = EBP_AB;  // [RQ1]
      EBP_AB: if (unit_tick && phase_cnt + 6'h01 >= phase_len)
                next_state = EBP_C;
      EBP_C:  if (phase_len == 6'h00 ||
                  (unit_tick && phase_cnt + 6'h01 >= phase_len))
                next_state = EBP_D;
      EBP_D:  if (phase_len == 6'h00 ||
                  (unit_tick && phase_cnt + 6'h01 >= phase_len))
                next_state = EBP_E;
      EBP_E:  if (unit_tick && phase_cnt + 6'h01 >= phase_len &&
                  (!ctrl[EBP_RDYEN_POS] || ready_ok))  // [RQ7] [RQ13]
                next_state = EBP_F;
      EBP_F:  if (phase_len == 6'h00 ||
                  (unit_tick && phase_cnt + 6'h01 >= phase_len))
                next_state = EBP_IDLE;
      default: next_state = EBP_IDLE;
    endcase
  end

  // State, unit and phase counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= EBP_IDLE;
      unit_cnt  <= 4'h0;
      phase_cnt <= 6'h00;
    end
    else
    begin
      state <= next_state;
      if (next_state != state || state == EBP_IDLE)
      begin
        unit_cnt  <= 4'h0;
        phase_cnt <= 6'h00;
      end
      else if (unit_tick)
      begin
        unit_cnt <= 4'h0;
        // Stop at the length so long ready waits never wrap
        if (phase_cnt < phase_len)
          phase_cnt <= phase_cnt + 6'h01;  // [RQ2]
      end
      else
        unit_cnt <= unit_cnt + 4'h1;
    end
  end

  // Command latch and window tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy      <= 1'b0;
      cmd_write <= 1'b0;
      last_addr <= '0;
    end
    else if (go)
    begin
      busy      <= 1'b1;
      cmd_write <= pwdata[EBP_WRITE_POS];
    end
    else if (state == EBP_F && next_state == EBP_IDLE)
    begin
      busy      <= 1'b0;
      last_addr <= cmd_addr;
    end
  end

  // Read capture on the edge that ends access; later address
  // changes do not reach this register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_data <= '0;
    else if (state == EBP_E && next_state == EBP_F && !cmd_write)
      read_data <= ctrl[EBP_MUX_POS] ? shared_addr_data_lines_in
                                     : data_lines_in;  // [RQ8] [RQ9] [RQ10]
  end

  // ===========================================================
  // Pin drivers, all registered; all but data_lines_out from next_state
  // ===========================================================
  // The go edge reads the command word itself, not the stale latch
  logic [1:0] cmd_sel;
  logic       cmd_ube;
  logic [1:0] sel_now;
  logic       ube_now;
  assign sel_now = go ? pwdata[EBP_CS_POS +: 2] : cmd_sel;
  assign ube_now = go ? pwdata[EBP_UBE_POS] : cmd_ube;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chip_select_n <= '1;
      read_n        <= 1'b1;
      write_n       <= 1'b1;
      addr_latch    <= 1'b0;
      address_lines <= '0;
      upper_byte_enable_n        <= 1'b1;
      data_lines_out             <= '0;
      data_lines_oen             <= 1'b1;
      shared_addr_data_lines_out <= '0;
      shared_addr_data_lines_oen <= 1'b1;
    end
    else
    begin
      chip_select_n <= '1;
      if (next_state != EBP_IDLE)
        chip_select_n[sel_now] <= 1'b0;  // [RQ15]
      read_n  <= !(next_state == EBP_E && !cmd_write);  // [RQ15]
      write_n <= !(next_state == EBP_E && cmd_write);
      addr_latch <= ctrl[EBP_MUX_POS] && next_state == EBP_AB;  // [RQ14]
      if (next_state != EBP_IDLE)
      begin
        address_lines       <= cmd_addr;
        upper_byte_enable_n <= !ube_now;
      end
      data_lines_out <= cmd_wdata;
      data_lines_oen <= !(!ctrl[EBP_MUX_POS] && cmd_write &&
                          (next_state == EBP_D || next_state == EBP_E ||
                           next_state == EBP_F));
      // Address in setup, then tristate turnaround, then write data
      shared_addr_data_lines_out <= (next_state == EBP_AB)
                                    ? cmd_addr[DW-1:0] : cmd_wdata;
      shared_addr_data_lines_oen <= !(ctrl[EBP_MUX_POS] &&
        (next_state == EBP_AB || (cmd_write &&
         (next_state == EBP_E || next_state == EBP_F))));  // [RQ14]
    end
  end

  // Chip select and byte enable from the command write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_sel <= 2'h0;
      cmd_ube <= 1'b0;
    end
    else if (go)
    begin
      cmd_sel <= pwdata[EBP_CS_POS +: 2];
      cmd_ube <= pwdata[EBP_UBE_POS];
    end
  end

  // ===========================================================
  // Checks
  // ===========================================================
  strobe_in_access_a: assert property (@(posedge pclk)  // [RQ15]
    disable iff (!presetn) !read_n || !write_n |-> state == EBP_E)
    else $error("strobe outside access");
  cs_whole_cycle_a: assert property (@(posedge pclk)  // [RQ15]
    disable iff (!presetn) state != EBP_IDLE |-> chip_select_n != '1)
    else $error("chip select dropped in cycle");
  phase_order_a: assert property (@(posedge pclk)  // [RQ1]
    disable iff (!presetn)
    state == EBP_IDLE && $past(state) != EBP_IDLE |-> $past(state) == EBP_F)
    else $error("cycle ended out of order");
  ready_wait_a: assert property (@(posedge pclk)  // [RQ13]
    disable iff (!presetn)
    state == EBP_E && ctrl[EBP_RDYEN_POS] && !ready_ok |=> state == EBP_E)
    else $error("access ended without ready");
  setup_min_a: assert property (@(posedge pclk)  // [RQ3]
    disable iff (!presetn) state == EBP_IDLE && go |=> state == EBP_AB)
    else $error("setup phase skipped");
  ale_setup_a: assert property (@(posedge pclk)  // [RQ14]
    disable iff (!presetn) addr_latch |-> state == EBP_AB)
    else $error("latch strobe outside setup");
  read_capture_a: assert property (@(posedge pclk)  // [RQ8]
    disable iff (!presetn)
    state == EBP_E && next_state == EBP_F && !cmd_write && !ctrl[EBP_MUX_POS]
    |=> read_data == $past(data_lines_in))
    else $error("read data not captured");
  busy_track_a: assert property (@(posedge pclk)  // [RQ1]
    disable iff (!presetn) busy |-> state != EBP_IDLE || $past(go))
    else $error("busy without cycle");

endmodule : ebp_sequencer

// ---- test/ebp_ext_mem.sv ----
/*
  Memory model at the far side of the external bus.
  Assumes registered sequencer pins and a pclk shared with them.
*/
`timescale 1ns/1ps
module ebp_ext_mem
  import ebp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        mux_mode,
  input  wire logic        act_low,
  input  wire logic [7:0]  rdy_wait,
  input  wire logic [23:0] address_lines,
  input  wire logic [15:0] data_lines_out,
  input  wire logic        data_lines_oen,
  output logic      [15:0] data_lines_in,
  input  wire logic [15:0] shared_addr_data_lines_out,
  input  wire logic        shared_addr_data_lines_oen,
  output logic      [15:0] shared_addr_data_lines_in,
  input  wire logic        addr_latch,
  input  wire logic [3:0]  chip_select_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  output logic             ready_in
);
  logic [15:0] mem [0:255];
  logic [15:0] drv;
  logic [15:0] last = 16'h5a5a;
  logic [15:0] lat  = 16'h0000;
  logic [7:0]  cnt  = 8'h00;
  logic [7:0]  idx;
  logic        strobe;

  // ==========================================================
  // Address, strobe and wire levels
  // ==========================================================
  assign strobe = !(read_n && write_n);
  assign idx    = mux_mode ? lat[7:0] : address_lines[7:0];
  // Data only while selected and read low; then it toggles
  // Toggling makes a capture taken one edge late show up at once
  assign drv = (!read_n && !(&chip_select_n)) ? mem[idx] : ~last;
  // Whoever enables its driver owns the wire
  assign data_lines_in = data_lines_oen ? drv : data_lines_out;
  assign shared_addr_data_lines_in =
    shared_addr_data_lines_oen ? drv : shared_addr_data_lines_out;
  // Ready after rdy_wait strobe clocks, dropped at strobe end
  assign ready_in = (strobe && cnt >= rdy_wait) ^ act_low;

  // ==========================================================
  // Storage
  // ==========================================================
  // Address latch, write capture and wait count
  always @(posedge pclk)
  begin
    last <= drv;
    cnt  <= strobe ? cnt + 8'h01 : 8'h00;
    if (addr_latch)
      lat <= shared_addr_data_lines_out;
    if (!write_n && !(&chip_select_n))
      mem[idx] <= mux_mode ? shared_addr_data_lines_in : data_lines_in;
  end
endmodule : ebp_ext_mem

// ---- test/ebp_sequencer_tb.sv ----
/*
  Self-checking bench of the external bus cycle sequencer.
  Assumes ebp_pkg, the sequencer and the memory model compiled first.
*/
`timescale 1ns/1ps
module ebp_sequencer_tb
  import ebp_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rdy_wait, prev_win;
  logic [31:0] pwdata, prdata, r;
  logic [23:0] address_lines, cur_addr;
  logic [15:0] data_lines_out, data_lines_in, wd;
  logic [15:0] shared_addr_data_lines_out, shared_addr_data_lines_in;
  logic        data_lines_oen, shared_addr_data_lines_oen, addr_latch;
  logic [3:0]  chip_select_n;
  logic        read_n, write_n, upper_byte_enable_n, ready_in, e;
  logic        mux_mode, act_low, in_cyc, in_st, cur_w;
  logic [15:0] mem_exp [int];
  int fail_count, n_compared, tick, ncyc, t_cs0, t_st0, t_st1, t_cs1;
  int tab, abx, c, d, ee, f, u, ren, cur_cs, ube, ext;

  ebp_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .address_lines(address_lines), .data_lines_out(data_lines_out),
    .data_lines_oen(data_lines_oen), .data_lines_in(data_lines_in),
    .shared_addr_data_lines_out(shared_addr_data_lines_out),
    .shared_addr_data_lines_oen(shared_addr_data_lines_oen),
    .shared_addr_data_lines_in(shared_addr_data_lines_in),
    .addr_latch(addr_latch), .chip_select_n(chip_select_n),
    .read_n(read_n), .write_n(write_n),
    .upper_byte_enable_n(upper_byte_enable_n), .ready_in(ready_in));

  ebp_ext_mem mem_model (.pclk(pclk), .mux_mode(mux_mode),
    .act_low(act_low), .rdy_wait(rdy_wait),
    .address_lines(address_lines), .data_lines_out(data_lines_out),
    .data_lines_oen(data_lines_oen), .data_lines_in(data_lines_in),
    .shared_addr_data_lines_out(shared_addr_data_lines_out),
    .shared_addr_data_lines_oen(shared_addr_data_lines_oen),
    .shared_addr_data_lines_in(shared_addr_data_lines_in),
    .addr_latch(addr_latch), .chip_select_n(chip_select_n),
    .read_n(read_n), .write_n(write_n), .ready_in(ready_in));

  // ==========================================================
  // Clock and shared tasks
  // ==========================================================
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      $display("[ERR] %s expected %h seen %h", n, x, g);
      fail_count++;
    end
  endtask : chk

  // One APB transfer; the idle edge at the end keeps strobes clean
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dat);
    int k;
    k = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    if (k >= 50)
    begin
      fail_count++;
      final_report();
    end
  endtask : apb

  // Start a cycle, try a refused second start, wait and check timing
  task automatic bus_cycle(input logic w);
    int k, n0, acc, eu;
    n0 = ncyc; k = 0; cur_w = w; eu = ee * u;
    ext = (cur_addr[23:16] != prev_win) ? abx : 0;
    apb(1'b1, EBP_CMD_OFS, {23'h0, ube[0], 2'h0, cur_cs[1:0], 3'h0, w});
    apb(1'b1, EBP_CMD_OFS, {31'h0, !w});
    do
    begin
      apb(1'b0, EBP_STATUS_OFS, 32'h0);
      k++;
    end while (r[0] !== 1'b0 && k < 500);
    if (k >= 500)
    begin
      fail_count++;
      final_report();
    end
    acc = t_st1 - t_st0;
    prev_win = cur_addr[23:16];
    chk("cycles", n0 + 1, ncyc);
    chk("setup", (tab + 1 + ext) * u + (c ? c * u : 1) + (d ? u : 1),
        t_st0 - t_cs0);
    if (!ren)
      chk("access", eu, acc);
    else
      chk("stretch", 1, acc >= eu && acc >= rdy_wait
          && acc <= eu + rdy_wait + 4 * u + 4);
    chk("hold", f ? f * u : 1, t_cs1 - t_st1);
  endtask : bus_cycle

  // ==========================================================
  // Pin monitor: phase edges and relations at every edge
  // ==========================================================
  always @(posedge pclk)
  begin
    if (presetn)
    begin
      if (!in_cyc && !(&chip_select_n))
      begin
        in_cyc = 1'b1;
        t_cs0 = tick;
        chk("cs_sel", ~(32'h1 << cur_cs), {28'hfffffff, chip_select_n});
      end
      if (!in_st && !(read_n && write_n))
      begin
        in_st = 1'b1;
        t_st0 = tick;
      end
      if (!(read_n && write_n))
      begin
        chk("strobe_pins", {~cur_w, ~ube[0], 1'b1},
            {write_n, upper_byte_enable_n, ~&chip_select_n});
        if (!mux_mode)
          chk("addr", cur_addr, address_lines);
      end
      if (in_st && read_n && write_n)
      begin
        in_st = 1'b0;
        t_st1 = tick;
      end
      if (in_cyc && &chip_select_n)
      begin
        in_cyc = 1'b0;
        t_cs1 = tick;
        ncyc++;
      end
      if (addr_latch)
        chk("latch", {cur_addr[15:0], 3'h7},
            {shared_addr_data_lines_out, mux_mode, read_n, write_n});
    end
    tick++;
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; mux_mode = 1'b0; act_low = 1'b0;
    rdy_wait = 8'h00; prev_win = 8'h00; in_cyc = 1'b0; in_st = 1'b0;
    fail_count = 0; n_compared = 0; tick = 0; ncyc = 0; cur_cs = 0;
    void'($urandom(59111));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped word
    apb(1'b0, EBP_TIMING_OFS, 32'h0);
    chk("timing_rst", EBP_TIMING_RST, r);
    apb(1'b0, EBP_CTRL_OFS, 32'h0);
    chk("ctrl_rst", EBP_CTRL_RST, r);
    chk("ctrl_rst_err", 32'h0, {31'h0, e});
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
    // First pass takes every phase maximum at one clock per unit, the rest are random
    for (int it = 0; it < 14; it++)
    begin
      tab = it ? $urandom % 2 : 1;
      abx = it ? $urandom % 4 : 3;
      c   = it ? $urandom % 4 : 3;
      d   = it ? $urandom % 2 : 1;
      ee  = it ? 1 + $urandom % 4 : 32;
      f   = it ? $urandom % 4 : 3;
      u   = it ? 1 + $urandom % 3 : 1;
      ren = it > 1 ? $urandom % 2 : 0;
      cur_cs = $urandom % 4;
      ube = $urandom % 2;
      cur_addr = {6'h0, it ? 2'($urandom) : 2'h1, 16'($urandom)};
      wd = 16'($urandom);
      mux_mode <= 1'($urandom);
      act_low <= 1'($urandom);
      rdy_wait <= 8'($urandom % 6);
      @(posedge pclk);
      apb(1'b1, EBP_TIMING_OFS, 32'(tab | abx << 1 | c << 3 | d << 5
          | (ee - 1) << 6 | f << 11 | (u - 1) << 16));
      apb(1'b0, EBP_TIMING_OFS, 32'h0);
      chk("timing", 32'(tab | abx << 1 | c << 3 | d << 5
          | (ee - 1) << 6 | f << 11 | (u - 1) << 16), r);
      apb(1'b1, EBP_CTRL_OFS, {28'h0, 1'($urandom), act_low,
          ren[0], mux_mode});
      apb(1'b1, EBP_ADDR_OFS, {8'h0, cur_addr});
      apb(1'b1, EBP_WDATA_OFS, {16'h0, wd});
      mem_exp[cur_addr[7:0]] = wd;
      bus_cycle(1'b1);
      bus_cycle(1'b0);
      apb(1'b0, EBP_RDATA_OFS, 32'h0);
      chk("rdata", {16'h0, mem_exp[cur_addr[7:0]]},
          {16'h0, r[15:0]});
    end
    final_report();
  end
endmodule : ebp_sequencer_tb
